// >>> rtl/retimer_defines.svh
// register offsets, field positions, reset values and counts of the channel
`ifndef RETIMER_DEFINES_SVH
`define RETIMER_DEFINES_SVH

// register offsets
`define REG_CTLE_OV_VAL  8'h03
`define REG_DIV_OUT      8'h09
`define REG_EYE_PWR      8'h11
`define REG_DIV_OV       8'h18
`define REG_MUX_OV       8'h1e
`define REG_EYE_OV       8'h22
`define REG_SCAN         8'h24
`define REG_CNT_HI       8'h25
`define REG_CNT_LO       8'h26
`define REG_HOPEN        8'h27
`define REG_VOPEN        8'h28
`define REG_ACC          8'h2a
`define REG_CTLE_CTRL    8'h2d
`define REG_SUB_CTLE     8'h3a
`define REG_LOCK_VAL     8'h3e
`define REG_CTLE_RB      8'h52
`define REG_THR          8'h6a

// field positions
`define BIT_CTLE_OV      3
`define BIT_RAW_SEL      5
`define BIT_DIV_OV       2
`define BIT_EYE_PD       5
`define EYE_RANGE_HI     7
`define EYE_RANGE_LO     6
`define MUX_HI           7
`define MUX_LO           5
`define DIVF_HI          6
`define DIVF_CODE_HI     5
`define DIVF_LO          4
`define BIT_EYE_OV       7
`define BIT_FAST         7
`define BIT_START        0
`define BIT_LV_EN        7
`define THR_H_HI         7
`define THR_H_LO         4
`define THR_V_HI         3
`define THR_V_LO         0

// reset values
`define RST_ZERO         8'h00
`define RST_EYE_PWR      8'h20
`define RST_MUX_OV       8'h20
`define RST_LOCK_VAL     8'h80
`define RST_THR          8'h44

// counts and codes
`define DIV_MAX          3'h3
`define DIV_BY4          2'h2
`define GRID_LAST        6'h3f
`define IDX_LAST         12'hfff
`define VOLT_MID         6'h20
`define ACC_SHIFT        2
`define MODE_ADAPT_LO    2'h1
`define MODE_ADAPT_HI    2'h3

`endif

// >>> rtl/retimer_pkg.sv
// shared types of the channel override and eye monitor logic
package retimer_pkg;

	// output multiplexer source codes
	typedef enum logic [2:0] {
		MUX_RAW     = 3'b000,
		MUX_RETIMED = 3'b001,
		MUX_PRBS    = 3'b100,
		MUX_MUTE    = 3'b111
	} outMux_e;

	// eye monitor sequencer
	typedef enum logic [1:0] {
		EYE_IDLE   = 2'b00,
		EYE_HSWEEP = 2'b01,
		EYE_VSWEEP = 2'b10,
		EYE_SCAN   = 2'b11
	} eyeState_e;

	// register port request from the serial management slave
	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} regReq_s;

	// controls toward the analog channel
	typedef struct packed {
		logic [7:0] ctleBoost;
		logic [1:0] divCode;
		outMux_e    outSel;
		logic       chanPowerDown;
		logic       eyePowerDown;
		logic [1:0] eyeRange;
	} analogCtl_s;

	// state of the error accumulator
	typedef struct packed {
		logic [15:0] cycles;
		logic [15:0] count;
		logic        done;
	} errCnt_s;

endpackage

// >>> rtl/eye_error_counter.sv
// counts offset/primary comparator disagreements over one interval
`include "retimer_defines.svh"
module eye_error_counter
	import retimer_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        restart,     // clears and starts an interval
	input  wire logic        primaryBit,  // decision of main comparator
	input  wire logic        offsetBit,   // decision of offset comparator
	input  wire logic [15:0] interval,    // cycles per interval
	output logic      [15:0] errCount,    // errors so far, saturating
	output logic             errDone      // interval complete, level
);

	errCnt_s q;  // registered state
	errCnt_s d;  // next state

	// accumulate while the interval runs; saturate instead of wrapping
	always_comb begin
		d = q;
		if (restart) begin
			d = '0;
		end else if (!q.done) begin
			d.cycles = q.cycles + 16'h0001;
			if ((primaryBit != offsetBit) && (q.count != 16'hffff)) begin
				d.count = q.count + 16'h0001;
			end
			if (d.cycles >= interval) begin
				d.done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clock) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign errCount = q.count;
	assign errDone  = q.done;

endmodule // eye_error_counter

// >>> rtl/retimer_channel_override_eye_monitor.sv
// per-channel ctle, output mux and divider overrides plus eye monitor
//
// Contract
// - ctle override bit applies the override boost
// - ctle override with modes 1-3 blocks lock
// - applied ctle value always readable
// - divide by 4 or 8 uses subrate ctle
// - no input signal powers down, mutes
// - unlocked follows mux field; locked raw/retimed; here locked follows mux field unless raw select is set
// - mux 111 mutes, 100 selects prbs
// - mux 001 retimed default, 000 raw
// - automatic divider from rate and subrate code
// - divider override bit uses divider field
// - divider field 0-3 maps 1,2,4,8
// - override ratio must be in group list
// - count offset/primary comparator disagreements per interval
// - error counts readable over 64x64 grid
// - phase sweep at mid level, then voltage
// - latest openings held in two registers
// - monitor power-down resets 1, 0 powers up
// - range and power-down share one register
// - small openings under validation restart acquisition
// - scan start bit self-clears, starts at once; here only from idle, a start during a validation sweep is dropped
// - range code selects 100 to 400 mV
// - upper count read advances and restarts counter
`include "retimer_defines.svh"
module retimer_channel_override_eye_monitor
	import retimer_pkg::*;
#(
	parameter logic [15:0] LV_PERIOD = 16'h03e8 // cycles between checks
) (
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire regReq_s    regReq,        // register port request
	output logic      [7:0] regRdData,     // read data, one cycle later
	input  wire logic       sigDetIn,      // signal detect, asynchronous
	input  wire logic       cdrLocked,     // clock recovery lock, same clock
	input  wire logic [7:0] adaptCtle,     // boost chosen by adaptation
	input  wire logic [1:0] ctleAdaptMode, // selected ctle adapt mode
	input  wire logic [1:0] rateDivCode,   // ratio found from bit rate/code
	input  wire logic [3:0] group0DivMask, // ratios in group-zero list
	input  wire logic       primaryBit,    // main comparator decision
	input  wire logic       offsetBit,     // offset comparator decision
	output analogCtl_s      anaCtl,        // controls toward the channel
	output logic      [5:0] eyePhase,      // offset comparator phase step
	output logic      [5:0] eyeVolt,       // offset comparator voltage step
	output logic            lockAllowed,   // acquisition may declare lock
	output logic            restartAcq     // lock lost, one-cycle pulse
);

	//////////////////////////////////////////////////////////////////////
	// state

	// every flip-flop of this module except those inside u_err lives in this one struct
	typedef struct packed {
		logic [7:0] ctleOvVal;
		logic [7:0] divOutCtrl;
		logic [7:0] eyePwrCtrl;
		logic [7:0] divOvVal;
		logic [7:0] muxOv;
		logic [7:0] eyeOvCtrl;
		logic [7:0] scanCtrl;
		logic [7:0] accTime;
		logic [7:0] ctleCtrl;
		logic [7:0] subCtle;
		logic [7:0] lockValCtrl;
		logic [7:0] thresholds;
		logic [7:0] ctleApplied;
		logic [7:0] hOpen;
		logic [7:0] vOpen;
		logic [7:0] cntHi;
		logic [7:0] cntLo;
		logic [7:0] rdData;
		eyeState_e  eyeSt;
		logic [5:0] phase;
		logic [5:0] volt;
		logic [11:0] scanIdx;
		logic [5:0] runStart;
		logic [6:0] runLen;
		logic [5:0] bestStart;
		logic [6:0] bestLen;
		logic [6:0] vCount;
		logic [15:0] lvTimer;
		logic [2:0] sync;
		logic       sigPresent;
		logic       cntRestart;
		logic       restartAcq;
		analogCtl_s ana;
	} state_s;

	state_s q;  // registered state
	state_s d;  // next state

	logic [15:0] errCount;    // current interval error count
	logic        errDone;     // interval finished
	logic [15:0] accCycles;   // interval length in clock cycles
	logic [1:0]  divNext;     // divider code now selected
	logic        ctleOvOn;    // ctle override enabled
	logic        pointOpen;   // current grid point saw no errors
	logic        pointReady;  // a fresh interval result is available

	//////////////////////////////////////////////////////////////////////
	// error accumulator

	// interval grows with the accumulation register, never zero
	assign accCycles = 16'(({8'h00, q.accTime} + 16'h0001) << `ACC_SHIFT);

	eye_error_counter u_err (
		.clock      (clock),
		.srst       (srst),
		.restart    (q.cntRestart),
		.primaryBit (primaryBit),
		.offsetBit  (offsetBit),
		.interval   (accCycles),
		.errCount   (errCount),
		.errDone    (errDone)
	);

	// done still shows the old interval during the restart cycle
	assign pointReady = errDone && !q.cntRestart;
	assign pointOpen  = (errCount == 16'h0000);

	//////////////////////////////////////////////////////////////////////
	// overrides seen by the analog side

	// override field limited to legal codes on write, low bits suffice
	assign divNext = q.divOutCtrl[`BIT_DIV_OV] ?
		q.divOvVal[`DIVF_CODE_HI:`DIVF_LO] :
		rateDivCode;
	assign ctleOvOn = q.ctleCtrl[`BIT_CTLE_OV];

	// lock is refused for the two documented misconfigurations
	assign lockAllowed =
		!(ctleOvOn && (ctleAdaptMode >= `MODE_ADAPT_LO) &&
		  (ctleAdaptMode <= `MODE_ADAPT_HI)) &&
		(!q.divOutCtrl[`BIT_DIV_OV] || group0DivMask[divNext]);

	//////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		logic [6:0] newLen;    // run length including this phase
		logic       hitLast;   // last step of a sweep
		newLen  = 7'h00;
		hitLast = 1'b0;
		d = q;
		d.restartAcq = 1'b0;
		d.cntRestart = 1'b0;

		// signal detect: a change counts once stages two and three agree
		d.sync = {q.sync[1:0], sigDetIn};
		if (q.sync[1] == q.sync[2]) begin
			d.sigPresent = q.sync[2];
		end

		// register writes
		if (regReq.wrEn) begin
			if (regReq.addr == `REG_CTLE_OV_VAL) begin
				d.ctleOvVal = regReq.wrData;
			end else if (regReq.addr == `REG_DIV_OUT) begin
				d.divOutCtrl = regReq.wrData;
			end else if (regReq.addr == `REG_EYE_PWR) begin
				d.eyePwrCtrl = regReq.wrData;
			end else if (regReq.addr == `REG_DIV_OV) begin
				d.divOvVal = regReq.wrData;
				// reserved codes leave the ratio that was in force
				if (regReq.wrData[`DIVF_HI:`DIVF_LO] > `DIV_MAX) begin
					d.divOvVal[`DIVF_HI:`DIVF_LO] =
						q.divOvVal[`DIVF_HI:`DIVF_LO];
				end
			end else if (regReq.addr == `REG_MUX_OV) begin
				d.muxOv = regReq.wrData;
			end else if (regReq.addr == `REG_EYE_OV) begin
				d.eyeOvCtrl = regReq.wrData;
			end else if (regReq.addr == `REG_SCAN) begin
				d.scanCtrl = regReq.wrData;
			end else if (regReq.addr == `REG_ACC) begin
				d.accTime = regReq.wrData;
			end else if (regReq.addr == `REG_CTLE_CTRL) begin
				d.ctleCtrl = regReq.wrData;
			end else if (regReq.addr == `REG_SUB_CTLE) begin
				d.subCtle = regReq.wrData;
			end else if (regReq.addr == `REG_LOCK_VAL) begin
				d.lockValCtrl = regReq.wrData;
			end else if (regReq.addr == `REG_THR) begin
				d.thresholds = regReq.wrData;
			end
		end

		// register reads; unmapped offsets read zero
		if (regReq.rdEn) begin
			d.rdData = 8'h00;
			if (regReq.addr == `REG_CTLE_OV_VAL) begin
				d.rdData = q.ctleOvVal;
			end else if (regReq.addr == `REG_DIV_OUT) begin
				d.rdData = q.divOutCtrl;
			end else if (regReq.addr == `REG_EYE_PWR) begin
				d.rdData = q.eyePwrCtrl;
			end else if (regReq.addr == `REG_DIV_OV) begin
				d.rdData = q.divOvVal;
			end else if (regReq.addr == `REG_MUX_OV) begin
				d.rdData = q.muxOv;
			end else if (regReq.addr == `REG_EYE_OV) begin
				d.rdData = q.eyeOvCtrl;
			end else if (regReq.addr == `REG_SCAN) begin
				d.rdData = q.scanCtrl;
			end else if (regReq.addr == `REG_CNT_HI) begin
				d.rdData = q.cntHi;
			end else if (regReq.addr == `REG_CNT_LO) begin
				d.rdData = q.cntLo;
			end else if (regReq.addr == `REG_HOPEN) begin
				d.rdData = q.hOpen;
			end else if (regReq.addr == `REG_VOPEN) begin
				d.rdData = q.vOpen;
			end else if (regReq.addr == `REG_ACC) begin
				d.rdData = q.accTime;
			end else if (regReq.addr == `REG_CTLE_CTRL) begin
				d.rdData = q.ctleCtrl;
			end else if (regReq.addr == `REG_SUB_CTLE) begin
				d.rdData = q.subCtle;
			end else if (regReq.addr == `REG_LOCK_VAL) begin
				d.rdData = q.lockValCtrl;
			end else if (regReq.addr == `REG_CTLE_RB) begin
				d.rdData = q.ctleApplied;
			end else if (regReq.addr == `REG_THR) begin
				d.rdData = q.thresholds;
			end
		end

		// periodic validation timer counts down to zero whether or not the check is armed
		if (q.lvTimer != 16'h0000) begin
			d.lvTimer = q.lvTimer - 16'h0001;
		end

		// eye monitor sequencer
		case (q.eyeSt)
			EYE_IDLE: begin
				if (regReq.wrEn && (regReq.addr == `REG_SCAN) &&
				    regReq.wrData[`BIT_FAST] &&
				    regReq.wrData[`BIT_START]) begin
					// external scan begins at once from grid origin
					d.eyeSt      = EYE_SCAN;
					d.scanIdx    = 12'h000;
					d.cntRestart = 1'b1;
				end else if (q.lockValCtrl[`BIT_LV_EN] && cdrLocked &&
				             !q.eyeOvCtrl[`BIT_EYE_OV] &&
				             (q.lvTimer == 16'h0000)) begin
					// only from idle, so a running scan is never disturbed
					d.eyeSt      = EYE_HSWEEP;
					d.phase      = 6'h00;
					d.volt       = `VOLT_MID;
					d.runLen     = 7'h00;
					d.bestLen    = 7'h00;
					d.bestStart  = 6'h00;
					d.cntRestart = 1'b1;
				end
			end
			EYE_HSWEEP: begin
				// phase sweep over one unit interval at mid level
				if (pointReady) begin
					hitLast = (q.phase == `GRID_LAST);
					if (pointOpen) begin
						newLen   = q.runLen + 7'h01;
						d.runLen = newLen;
						if (q.runLen == 7'h00) begin
							d.runStart = q.phase;
						end
						if (newLen > q.bestLen) begin
							d.bestLen   = newLen;
							d.bestStart = (q.runLen == 7'h00) ?
								q.phase : q.runStart;
						end
					end else begin
						d.runLen = 7'h00;
					end
					if (hitLast) begin
						// park phase on the centre of the widest run
						d.hOpen  = {1'b0, d.bestLen};
						d.phase  = 6'(d.bestStart + d.bestLen[6:1]);
						d.volt   = 6'h00;
						d.vCount = 7'h00;
						d.eyeSt  = EYE_VSWEEP;
					end else begin
						d.phase = q.phase + 6'h01;
					end
					d.cntRestart = 1'b1;
				end
			end
			EYE_VSWEEP: begin
				// voltage sweep with phase held at the centre
				if (pointReady) begin
					if (pointOpen) begin
						d.vCount = q.vCount + 7'h01;
					end
					if (q.volt == `GRID_LAST) begin
						d.vOpen = {1'b0, d.vCount};
						// threshold nibbles compare in steps of four
						if (({1'b0, d.vCount} <
						     {2'b00, q.thresholds[`THR_V_HI:`THR_V_LO],
						      2'b00}) ||
						    (q.hOpen <
						     {2'b00, q.thresholds[`THR_H_HI:`THR_H_LO],
						      2'b00})) begin
							d.restartAcq = 1'b1;
						end
						d.volt    = `VOLT_MID;
						d.lvTimer = LV_PERIOD;
						d.eyeSt   = EYE_IDLE;
					end else begin
						d.volt       = q.volt + 6'h01;
						d.cntRestart = 1'b1;
					end
				end
			end
			EYE_SCAN: begin
				// keep the last finished count for the register port
				if (pointReady) begin
					d.cntHi = errCount[15:8];
					d.cntLo = errCount[7:0];
				end
				if (!d.scanCtrl[`BIT_FAST]) begin
					d.eyeSt = EYE_IDLE;
				end else if (regReq.rdEn &&
				             (regReq.addr == `REG_CNT_HI)) begin
					if (q.scanIdx == `IDX_LAST) begin
						d.eyeSt = EYE_IDLE;
					end else begin
						d.scanIdx    = q.scanIdx + 12'h001;
						d.cntRestart = 1'b1;
					end
				end
				d.phase = d.scanIdx[11:6];
				d.volt  = d.scanIdx[5:0];
			end
			default: begin
				d.eyeSt = EYE_IDLE;
			end
		endcase

		// start bit reads back set only while the scan is running
		d.scanCtrl[`BIT_START] = (d.eyeSt == EYE_SCAN);

		// ctle: subrate level beats override beats adaptation
		if (divNext >= `DIV_BY4) begin
			d.ctleApplied = q.subCtle;
		end else if (ctleOvOn) begin
			d.ctleApplied = q.ctleOvVal;
		end else begin
			d.ctleApplied = adaptCtle;
		end
		d.ana.ctleBoost = d.ctleApplied;
		d.ana.divCode   = divNext;

		// output source
		if (!q.sigPresent) begin
			d.ana.outSel = MUX_MUTE;
		end else if (cdrLocked && q.divOutCtrl[`BIT_RAW_SEL]) begin
			d.ana.outSel = MUX_RAW;
		end else begin
			case (q.muxOv[`MUX_HI:`MUX_LO])
				MUX_MUTE:    d.ana.outSel = MUX_MUTE;
				MUX_PRBS:    d.ana.outSel = MUX_PRBS;
				MUX_RAW:     d.ana.outSel = MUX_RAW;
				default:     d.ana.outSel = MUX_RETIMED;
			endcase
		end
		d.ana.chanPowerDown = !q.sigPresent;

		// monitor wakes for periodic sweeps or when software clears pd
		d.ana.eyePowerDown = q.eyePwrCtrl[`BIT_EYE_PD] &&
			(q.eyeSt != EYE_HSWEEP) && (q.eyeSt != EYE_VSWEEP);
		d.ana.eyeRange =
			q.eyePwrCtrl[`EYE_RANGE_HI:`EYE_RANGE_LO];
	end

	//////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clock) begin
		if (srst) begin
			q             <= '0;
			q.eyePwrCtrl  <= `RST_EYE_PWR;
			q.muxOv       <= `RST_MUX_OV;
			q.lockValCtrl <= `RST_LOCK_VAL;
			q.thresholds  <= `RST_THR;
			q.volt        <= `VOLT_MID;
			q.lvTimer     <= LV_PERIOD;
			q.ana.outSel  <= MUX_MUTE;
			q.ana.chanPowerDown <= 1'b1;
			q.ana.eyePowerDown  <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign regRdData  = q.rdData;
	assign anaCtl     = q.ana;
	assign eyePhase   = q.phase;
	assign eyeVolt    = q.volt;
	assign restartAcq = q.restartAcq;

	//////////////////////////////////////////////////////////////////////
	// assertions

	a_ctle_override: assert property (@(posedge clock) disable iff (srst)
		(ctleOvOn && (divNext < `DIV_BY4)) |=>
		(q.ctleApplied == $past(q.ctleOvVal)))
		else $error("override boost not applied");

	a_lock_blocked: assert property (@(posedge clock) disable iff (srst)
		(ctleOvOn && (ctleAdaptMode != 2'h0)) |-> !lockAllowed)
		else $error("lock allowed with ctle override");

	a_readback_ctle: assert property (@(posedge clock) disable iff (srst)
		(regReq.rdEn && (regReq.addr == `REG_CTLE_RB)) |=>
		(regRdData == $past(q.ctleApplied)) && (anaCtl.ctleBoost ==
		q.ctleApplied))
		else $error("ctle readback mismatch");

	a_subrate_ctle: assert property (@(posedge clock) disable iff (srst)
		(divNext >= `DIV_BY4) |=> (anaCtl.ctleBoost == $past(q.subCtle)))
		else $error("subrate ctle not applied");

	a_mute_nosig: assert property (@(posedge clock) disable iff (srst)
		!q.sigPresent |=> (anaCtl.outSel == MUX_MUTE) &&
		anaCtl.chanPowerDown)
		else $error("channel not muted without signal");

	a_prbs_select: assert property (@(posedge clock) disable iff (srst)
		(q.sigPresent && !cdrLocked &&
		 (q.muxOv[`MUX_HI:`MUX_LO] == 3'b100)) |=>
		(anaCtl.outSel == MUX_PRBS))
		else $error("prbs source not selected");

	a_div_override: assert property (@(posedge clock) disable iff (srst)
		q.divOutCtrl[`BIT_DIV_OV] |=>
		(anaCtl.divCode == $past(q.divOvVal[`DIVF_CODE_HI:`DIVF_LO])))
		else $error("divider override ignored");

	a_div_reserved: assert property (@(posedge clock) disable iff (srst)
		(regReq.wrEn && (regReq.addr == `REG_DIV_OV) &&
		 (regReq.wrData[`DIVF_HI:`DIVF_LO] > `DIV_MAX)) |=>
		(q.divOvVal[`DIVF_HI:`DIVF_LO] ==
		 $past(q.divOvVal[`DIVF_HI:`DIVF_LO])))
		else $error("reserved divider code accepted");

	a_scan_advance: assert property (@(posedge clock) disable iff (srst)
		((q.eyeSt == EYE_SCAN) && q.scanCtrl[`BIT_FAST] && regReq.rdEn &&
		 (regReq.addr == `REG_CNT_HI) && (q.scanIdx != `IDX_LAST)) |=>
		(q.scanIdx == $past(q.scanIdx) + 12'h001) && q.cntRestart)
		else $error("scan did not advance on upper read");

	a_pd_reset: assert property (@(posedge clock)
		$fell(srst) |-> q.eyePwrCtrl[`BIT_EYE_PD] && anaCtl.eyePowerDown)
		else $error("monitor not powered down after reset");

endmodule // retimer_channel_override_eye_monitor

// >>> tb/sys_controller_model.sv
// system controller model that issues register port requests
module sys_controller_model
	import retimer_pkg::*;
(
	input  wire logic clock,
	output regReq_s   regReq
);
	timeunit 1ns;
	timeprecision 1ns;

	// port idle from time zero
	initial regReq = '0;

	// one request, taken at the next edge; the leading edge wait keeps
	// two requests from being assigned in the same time step
	task automatic access(input logic wr, input logic [7:0] a, d);
		@(posedge clock);
		#1 regReq = '{wrEn: wr, rdEn: !wr, addr: a, wrData: d};
		@(posedge clock);
		#1 regReq = '0;
	endtask
endmodule // sys_controller_model

// >>> tb/retimer_channel_override_eye_monitor_tb_top.sv
// self-checking bench of the channel override and eye monitor block
module retimer_channel_override_eye_monitor_tb_top
	import retimer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {string name; logic [7:0] v;} note_s; // one expectation
	logic       clock = 0;
	logic       srst = 1;
	regReq_s    regReq;
	logic [7:0] regRdData;
	logic       sigDetIn = 1;
	logic       cdrLocked = 0;
	logic [7:0] adaptCtle = 8'h00;
	logic [1:0] ctleAdaptMode = 2'h0;
	logic [1:0] rateDivCode = 2'h0;
	logic [3:0] group0DivMask = 4'hf;
	logic       primaryBit = 0;
	logic       diffOn = 0;      // offset comparator disagrees when high
	wire        offsetBit = primaryBit ^ diffOn;
	analogCtl_s anaCtl;
	logic [5:0] eyePhase;
	logic [5:0] eyeVolt;
	logic       lockAllowed;
	logic       restartAcq;
	logic       rdPend = 0;      // a read answer is due this cycle
	logic       seenRestart = 0; // restart pulse caught
	int         n_errors = 0;
	int         n_checks = 0;
	integer     seed = 32'hcc2da743;
	note_s      q[$];            // expectations, oldest first
	event       probeEv;
	logic [7:0] r;
	logic [7:0] s;
	int         i;
	logic [11:0] muxCodes = 12'h067; // raw, retimed, prbs, mute codes

	always #50 clock = ~clock;

	retimer_channel_override_eye_monitor #(.LV_PERIOD(16'h0010)) dut (
		.clock(clock), .srst(srst), .regReq(regReq), .regRdData(regRdData),
		.sigDetIn(sigDetIn), .cdrLocked(cdrLocked), .adaptCtle(adaptCtle),
		.ctleAdaptMode(ctleAdaptMode), .rateDivCode(rateDivCode),
		.group0DivMask(group0DivMask), .primaryBit(primaryBit),
		.offsetBit(offsetBit), .anaCtl(anaCtl), .eyePhase(eyePhase),
		.eyeVolt(eyeVolt), .lockAllowed(lockAllowed),
		.restartAcq(restartAcq));

	sys_controller_model ctl (.clock(clock), .regReq(regReq));

	////////////////////////////////////////////////////////////////////////
	// random comparator data, the offset decision derived from it
	always @(posedge clock) begin
		#1 primaryBit = 1'($random(seed));
	end

	// the restart pulse lasts one cycle, so it is latched for the probe
	always @(posedge clock) begin
		rdPend <= regReq.rdEn;
		if (restartAcq === 1'b1) seenRestart <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// result side: takes the oldest note and compares
	task automatic take(input logic [7:0] seen);
		note_s e;
		e = q.pop_front();
		n_checks++;
		if (e.v !== seen) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", e.name, e.v, seen);
		end
	endtask

	function automatic logic [7:0] pick(input string n);
		case (n)
			"outSel":  pick = {4'h0, anaCtl.chanPowerDown, anaCtl.outSel};
			"divCode": pick = {6'h0, anaCtl.divCode};
			"eyeCtl":  pick = {5'h0, anaCtl.eyePowerDown, anaCtl.eyeRange};
			"lock":    pick = {7'h0, lockAllowed};
			"restart": pick = {7'h0, seenRestart};
			default:   pick = {2'h0, eyeVolt};
		endcase
	endfunction

	// read data is settled by the falling edge after the answer edge
	always @(negedge clock) begin
		if (rdPend) take(regRdData);
	end
	always @(probeEv) take(pick(q[0].name));

	////////////////////////////////////////////////////////////////////////
	// driver side: reads note the expectation, then make the request
	task automatic wr(input logic [7:0] a, d);
		ctl.access(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, e);
		q.push_back('{"read", e});
		ctl.access(1'b0, a, 8'h00);
	endtask
	// level outputs settle within two edges of the cause; the caller is
	// held until the next edge so its next input change cannot race the
	// compare that the event wakes up
	task automatic probe(input string n, input logic [7:0] e);
		repeat (2) @(posedge clock);
		#1 q.push_back('{n, e});
		->probeEv;
		@(posedge clock);
		#1;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// a hang is cut short well past the expected few thousand cycles
	initial begin
		#3000000;
		n_errors++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (2) @(posedge clock);
		#1 srst = 0;
		adaptCtle = 8'($random(seed));
		rd(8'h11, 8'h20);
		rd(8'h1e, 8'h20);
		rd(8'h3e, 8'h80);
		rd(8'h6a, 8'h44);
		rd(8'h40, 8'h00);
		wr(8'h3e, 8'h00);
		r = 8'($random(seed));
		wr(8'h03, r);
		wr(8'h27, 8'hff);
		rd(8'h03, r);
		rd(8'h27, 8'h00);
		$display("test registers done");
		rd(8'h52, adaptCtle);
		wr(8'h2d, 8'h08);
		rd(8'h52, r);
		ctleAdaptMode = 2'h1;
		probe("lock", 8'h00);
		ctleAdaptMode = 2'h0;
		probe("lock", 8'h01);
		rateDivCode = 2'h2;
		s = 8'($random(seed));
		wr(8'h3a, s);
		rd(8'h52, s);
		probe("divCode", 8'h02);
		$display("test ctle done");
		wr(8'h09, 8'h04);
		for (i = 0; i < 4; i++) begin
			wr(8'h18, 8'(i << 4));
			probe("divCode", 8'(i));
		end
		wr(8'h18, 8'h50);
		rd(8'h18, 8'h30);
		group0DivMask = 4'h7;
		probe("lock", 8'h00);
		group0DivMask = 4'hf;
		$display("test divider done");
		for (i = 0; i < 4; i++) begin
			s = {5'h00, muxCodes[9 - 3 * i +: 3]};
			wr(8'h1e, 8'(s << 5));
			probe("outSel", s);
		end
		cdrLocked = 1;
		wr(8'h09, 8'h24);
		probe("outSel", 8'h00);
		sigDetIn = 0;
		repeat (4) @(posedge clock);
		probe("outSel", 8'h0f);
		sigDetIn = 1;
		$display("test output done");
		wr(8'h11, 8'hc0);
		probe("eyeCtl", 8'h03);
		wr(8'h11, 8'h20);
		probe("eyeCtl", 8'h04);
		diffOn = 1;
		wr(8'h2a, 8'h01);
		wr(8'h24, 8'h81);
		rd(8'h24, 8'h81);
		repeat (30) @(posedge clock);
		rd(8'h25, 8'h00);
		probe("eyeVolt", 8'h01);
		rd(8'h26, 8'h08);
		wr(8'h24, 8'h00);
		$display("test scan done");
		wr(8'h3e, 8'h80);
		for (i = 0; i < 5000 && seenRestart !== 1'b1; i++) @(posedge clock);
		probe("restart", 8'h01);
		rd(8'h27, 8'h00);
		rd(8'h28, 8'h00);
		// clean comparators: after one full sweep every point is open
		diffOn = 0;
		repeat (3000) @(posedge clock);
		rd(8'h27, 8'h40);
		rd(8'h28, 8'h40);
		$display("test opening check done");
		conclude();
	end
endmodule // retimer_channel_override_eye_monitor_tb_top
